// *** emmcxm_bank.sv ***
// emmcxm_bank: mode-segment register bank, bytes 0..59, with retention classes
// assumes a byte register port and a link clock from outside the domain
`timescale 1ns/1ns
module emmcxm_bank #(
   parameter longint unsigned INIT_NORMAL_CYC = emmcxm_pkg::INIT_NORMAL_CYC,
   parameter longint unsigned INIT_PART_CYC   = emmcxm_pkg::INIT_PART_CYC,
   parameter longint unsigned SHUTDOWN_CYC    = emmcxm_pkg::SHUTDOWN_CYC
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        power_on_rst,
   input  wire logic        hw_rst_n,
   input  wire logic        cmd0_rst,
   input  wire logic [5:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   input  wire logic        link_clk,
   input  wire logic        read_burst,
   input  wire logic        crc_status,
   input  wire logic [7:0]  fw_result_in,
   input  wire logic [7:0]  batch_fail_in,
   input  wire logic [7:0]  batch_result_in,
   input  wire logic [15:0] exc_flags_in,
   input  wire logic [7:0]  groups_rel_in,
   output logic             init_done,
   output logic             init_timeout,
   output logic             shutdown_ready,
   output logic             read_strobe_pin_o,
   output logic             read_strobe_pin_oe,
   output logic             cache_flush_pulse
);
   // pin synchronisers
   logic [1:0] hwr_sync_q;
   logic [1:0] lclk_sync_q;
   logic       lclk_prev_q;
   logic       hard_rst;
   logic       any_rst;
   logic       link_edge;

   always_ff @(posedge clock) begin
      if (srst) begin
         hwr_sync_q  <= 2'b11;
         lclk_sync_q <= 2'b00;
         lclk_prev_q <= 1'b0;
      end else begin
         hwr_sync_q  <= {hwr_sync_q[0], hw_rst_n};
         lclk_sync_q <= {lclk_sync_q[0], link_clk};
         lclk_prev_q <= lclk_sync_q[1];
      end
   end

   // hard reset = power loss or hw reset pin; cmd0 only clears volatile fields
   // kept apart from cmd0 so a power-cleared field would clear only here
   assign hard_rst  = srst || power_on_rst || !hwr_sync_q[1];
   assign any_rst   = hard_rst || cmd0_rst;
   assign link_edge = lclk_sync_q[1] != lclk_prev_q;

   logic wr_hit;
   assign wr_hit = wr && !hard_rst;

   // persistent, readable: removal method, awareness enable
   logic [7:0] sec_removal_q;
   logic [7:0] prod_aware_q;
   always_ff @(posedge clock) begin
      if (power_on_rst && srst) begin
         sec_removal_q <= emmcxm_pkg::RST_SEC_REMOVAL;
         prod_aware_q  <= emmcxm_pkg::RST_PROD_AWARE;
      end else if (wr_hit) begin
         if (addr == emmcxm_pkg::OFF_SEC_REMOVAL) begin
            sec_removal_q <= wdata;
         end
         if (addr == emmcxm_pkg::OFF_PROD_AWARE) begin
            prod_aware_q <= wdata;
         end
      end
   end

   // volatile readable bytes
   logic [7:0]  cmdq_en_q;
   logic [7:0]  mode_sel_q;
   logic [7:0]  cache_on_q;
   logic [7:0]  shutdown_q;
   logic [15:0] exc_mask_q;
   logic [7:0]  class6_q;
   logic [7:0]  stb_ctrl_q;
   always_ff @(posedge clock) begin
      if (any_rst) begin
         cmdq_en_q  <= emmcxm_pkg::RST_ZERO;
         mode_sel_q <= emmcxm_pkg::RST_ZERO;
         cache_on_q <= emmcxm_pkg::RST_ZERO;
         shutdown_q <= emmcxm_pkg::RST_ZERO;
         exc_mask_q <= 16'h0000;
         class6_q   <= emmcxm_pkg::RST_ZERO;
         stb_ctrl_q <= emmcxm_pkg::RST_ZERO;
      end else if (wr) begin
         case (addr)
            emmcxm_pkg::OFF_CMDQ_EN:      cmdq_en_q        <= wdata;
            emmcxm_pkg::OFF_MODE_SELECT:  mode_sel_q       <= wdata;
            emmcxm_pkg::OFF_CACHE_ONOFF:  cache_on_q       <= wdata;
            emmcxm_pkg::OFF_SHUTDOWN:     shutdown_q       <= wdata;
            emmcxm_pkg::OFF_EXC_MASK_LO:  exc_mask_q[7:0]  <= wdata;
            emmcxm_pkg::OFF_EXC_MASK_HI:  exc_mask_q[15:8] <= wdata;
            emmcxm_pkg::OFF_CLASS6_SEL:   class6_q         <= wdata;
            emmcxm_pkg::OFF_STROBE_CTRL:  stb_ctrl_q       <= wdata;
            default: ;
         endcase
      end
   end

   // volatile write-only: mode opcode, flush trigger; never read back
   logic [7:0] mode_op_q;
   always_ff @(posedge clock) begin
      if (any_rst) begin
         mode_op_q         <= emmcxm_pkg::RST_ZERO;
         cache_flush_pulse <= 1'b0;
      end else begin
         cache_flush_pulse <= wr && addr == emmcxm_pkg::OFF_CACHE_FLUSH && wdata[0];
         if (wr && addr == emmcxm_pkg::OFF_MODE_OPCODE) begin
            mode_op_q <= wdata;
         end
      end
   end

   // preload size / context / partition attrs live in the byte store; their
   // contents are volatile, cleared by a walk after reset instead of per flop
   logic       clr_active_q;
   logic [5:0] clr_addr_q;
   logic       mem_we;
   logic [5:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic       mem_sel;

   always_ff @(posedge clock) begin
      if (any_rst) begin
         clr_active_q <= 1'b1;
         clr_addr_q   <= 6'h00;
      end else if (clr_active_q) begin
         clr_addr_q <= clr_addr_q + 6'h01;
         if (clr_addr_q == 6'h3f) begin
            clr_active_q <= 1'b0;
         end
      end
   end

   assign mem_sel = (addr >= emmcxm_pkg::OFF_PRELOAD && addr < emmcxm_pkg::OFF_FW_RESULT)
                 || (addr >= emmcxm_pkg::OFF_CONTEXT_LO && addr <= emmcxm_pkg::OFF_EXT_PART_HI);
   assign mem_we    = clr_active_q || (wr && mem_sel);
   assign mem_waddr = clr_active_q ? clr_addr_q : addr;
   assign mem_wdata = clr_active_q ? emmcxm_pkg::RST_ZERO : wdata;

   emmcxm_mem #(.DEPTH(64), .AW(6)) u_mem (
      .clock (clock),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr  (addr),
      .rsel   (rd && mem_sel),
      .bypass (rd ? rd_mux : 8'h00),
      .rdata  (rdata)
   );

   // read-only view: max preload size and device status
   logic [31:0] max_preload;
   assign max_preload = emmcxm_pkg::RST_MAX_PRELOAD;

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (addr)
         emmcxm_pkg::OFF_CMDQ_EN:        rd_mux = cmdq_en_q;
         emmcxm_pkg::OFF_SEC_REMOVAL:    rd_mux = sec_removal_q;
         emmcxm_pkg::OFF_PROD_AWARE:     rd_mux = prod_aware_q;
         emmcxm_pkg::OFF_MAX_PRELOAD:    rd_mux = max_preload[7:0];
         6'h13:                          rd_mux = max_preload[15:8];
         6'h14:                          rd_mux = max_preload[23:16];
         6'h15:                          rd_mux = max_preload[31:24];
         emmcxm_pkg::OFF_FW_RESULT:      rd_mux = fw_result_in;
         emmcxm_pkg::OFF_MODE_SELECT:    rd_mux = mode_sel_q;
         emmcxm_pkg::OFF_CACHE_ONOFF:    rd_mux = cache_on_q;
         emmcxm_pkg::OFF_SHUTDOWN:       rd_mux = shutdown_q;
         emmcxm_pkg::OFF_BATCH_FAIL:     rd_mux = batch_fail_in;
         emmcxm_pkg::OFF_BATCH_RESULT:   rd_mux = batch_result_in;
         emmcxm_pkg::OFF_EXC_FLAGS_LO:   rd_mux = exc_flags_in[7:0];
         emmcxm_pkg::OFF_EXC_FLAGS_HI:   rd_mux = exc_flags_in[15:8];
         emmcxm_pkg::OFF_EXC_MASK_LO:    rd_mux = exc_mask_q[7:0];
         emmcxm_pkg::OFF_EXC_MASK_HI:    rd_mux = exc_mask_q[15:8];
         emmcxm_pkg::OFF_GROUPS_REL:     rd_mux = groups_rel_in;
         emmcxm_pkg::OFF_CLASS6_SEL:     rd_mux = class6_q;
         emmcxm_pkg::OFF_STROBE_CTRL:    rd_mux = stb_ctrl_q;
         // opcode and flush are write-only: read as zero
         default:                        rd_mux = 8'h00;
      endcase
   end

   // initialisation timer: limit depends on partitioning
   logic [emmcxm_pkg::CNT_W-1:0] init_cnt_q;
   logic [emmcxm_pkg::CNT_W-1:0] init_lim;
   assign init_lim = stb_ctrl_q[emmcxm_pkg::STB_PART_BIT]
                   ? emmcxm_pkg::CNT_W'(INIT_PART_CYC)
                   : emmcxm_pkg::CNT_W'(INIT_NORMAL_CYC);
   always_ff @(posedge clock) begin
      if (any_rst) begin
         init_cnt_q   <= '0;
         init_done    <= 1'b0;
         init_timeout <= 1'b0;
      end else if (!init_done) begin
         // device finishes well inside the limit once the clear walk ends
         if (!clr_active_q) begin
            init_done <= 1'b1;
         end
         init_cnt_q <= init_cnt_q + 1'b1;
         if (init_cnt_q + 1'b1 >= init_lim) begin
            init_timeout <= 1'b1;
         end
      end
   end

   // short shutdown notice: ready within the bound
   logic [emmcxm_pkg::CNT_W-1:0] sd_cnt_q;
   always_ff @(posedge clock) begin
      if (any_rst || shutdown_q == 8'h00) begin
         sd_cnt_q       <= '0;
         shutdown_ready <= 1'b0;
      end else if (!shutdown_ready) begin
         sd_cnt_q <= sd_cnt_q + 1'b1;
         if (sd_cnt_q >= emmcxm_pkg::CNT_W'(SHUTDOWN_CYC) - 2) begin
            shutdown_ready <= 1'b1;
         end
      end
   end

   emmcxm_strobe u_strobe (
      .clock      (clock),
      .srst       (srst),
      .hs400      (stb_ctrl_q[emmcxm_pkg::STB_HS400_BIT]),
      .link_edge  (link_edge),
      .read_burst (read_burst),
      .crc_status (crc_status),
      .stb_out    (read_strobe_pin_o),
      .stb_oe     (read_strobe_pin_oe)
   );

   // bus-side checks plus one strobe enable check; the strobe module keeps its own beside its logic
   property p_ro_hold;
      @(posedge clock) disable iff (srst)
      rd && addr == emmcxm_pkg::OFF_MAX_PRELOAD |=> rdata == 8'h00;
   endproperty
   a_ro_hold: assert property (p_ro_hold)
      else $error("read-only max preload byte wrong");

   property p_ro_status;
      @(posedge clock) disable iff (srst)
      rd && addr == emmcxm_pkg::OFF_FW_RESULT |=> rdata == $past(fw_result_in);
   endproperty
   a_ro_status: assert property (p_ro_status)
      else $error("read-only status byte not shown");

   property p_wo_zero;
      @(posedge clock) disable iff (srst)
      rd && addr == emmcxm_pkg::OFF_MODE_OPCODE |=> rdata == 8'h00;
   endproperty
   a_wo_zero: assert property (p_wo_zero)
      else $error("write-only opcode leaked on read");

   property p_pers_keep;
      @(posedge clock) disable iff (srst)
      cmd0_rst && !wr |=> $stable(sec_removal_q);
   endproperty
   a_pers_keep: assert property (p_pers_keep)
      else $error("persistent field lost on cmd0");

   property p_vol_clear;
      @(posedge clock) disable iff (srst)
      cmd0_rst |=> cmdq_en_q == 8'h00 && class6_q == 8'h00;
   endproperty
   a_vol_clear: assert property (p_vol_clear)
      else $error("volatile field kept across cmd0");

   property p_clear_walk;
      @(posedge clock) disable iff (srst)
      $fell(clr_active_q) |-> clr_addr_q == 6'h00;
   endproperty
   a_clear_walk: assert property (p_clear_walk)
      else $error("clear walk stopped short of the last byte");

   property p_flush_once;
      @(posedge clock) disable iff (srst)
      cache_flush_pulse |-> $past(wr) && $past(addr) == emmcxm_pkg::OFF_CACHE_FLUSH;
   endproperty
   a_flush_once: assert property (p_flush_once)
      else $error("flush pulse without a flush write");

   property p_wr_back;
      @(posedge clock) disable iff (srst || any_rst)
      wr && addr == emmcxm_pkg::OFF_CLASS6_SEL && !cmd0_rst |=> class6_q == $past(wdata);
   endproperty
   a_wr_back: assert property (p_wr_back)
      else $error("written byte not stored");

   property p_init_in_time;
      @(posedge clock) disable iff (srst)
      init_done |-> !init_timeout;
   endproperty
   a_init_in_time: assert property (p_init_in_time)
      else $error("init finished after its limit");

   property p_init_flag;
      @(posedge clock) disable iff (srst)
      init_timeout |-> init_cnt_q >= init_lim - 1;
   endproperty
   a_init_flag: assert property (p_init_flag)
      else $error("init timeout raised early");

   property p_sd_idle;
      @(posedge clock) disable iff (srst)
      shutdown_q == 8'h00 |=> !shutdown_ready;
   endproperty
   a_sd_idle: assert property (p_sd_idle)
      else $error("shutdown ready without notice");

   property p_sd_bound;
      @(posedge clock) disable iff (srst)
      shutdown_q != 8'h00 && !shutdown_ready
      |-> sd_cnt_q < emmcxm_pkg::CNT_W'(SHUTDOWN_CYC);
   endproperty
   a_sd_bound: assert property (p_sd_bound)
      else $error("shutdown preparation overran its bound");

   property p_stb_off;
      @(posedge clock) disable iff (srst)
      !stb_ctrl_q[emmcxm_pkg::STB_HS400_BIT] ##1 !stb_ctrl_q[emmcxm_pkg::STB_HS400_BIT]
      |-> !read_strobe_pin_oe;
   endproperty
   a_stb_off: assert property (p_stb_off)
      else $error("strobe driven outside hs400");
endmodule // emmcxm_bank

// *** emmcxm_pkg.sv ***
// emmcxm_pkg: constants for the mode-segment register bank (bytes 0..59)
// assumes a 100 MHz core clock; byte offsets address single bytes
package emmcxm_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned NBYTES = 60;

   // register byte offsets
   localparam logic [5:0] OFF_CMDQ_EN      = 6'h0f;
   localparam logic [5:0] OFF_SEC_REMOVAL  = 6'h10;
   localparam logic [5:0] OFF_PROD_AWARE   = 6'h11;
   localparam logic [5:0] OFF_MAX_PRELOAD  = 6'h12;
   localparam logic [5:0] OFF_PRELOAD      = 6'h16;
   localparam logic [5:0] OFF_FW_RESULT    = 6'h1a;
   localparam logic [5:0] OFF_MODE_OPCODE  = 6'h1d;
   localparam logic [5:0] OFF_MODE_SELECT  = 6'h1e;
   localparam logic [5:0] OFF_CACHE_FLUSH  = 6'h20;
   localparam logic [5:0] OFF_CACHE_ONOFF  = 6'h21;
   localparam logic [5:0] OFF_SHUTDOWN     = 6'h22;
   localparam logic [5:0] OFF_BATCH_FAIL   = 6'h23;
   localparam logic [5:0] OFF_BATCH_RESULT = 6'h24;
   localparam logic [5:0] OFF_CONTEXT_LO   = 6'h25;
   localparam logic [5:0] OFF_CONTEXT_HI   = 6'h33;
   localparam logic [5:0] OFF_EXT_PART_LO  = 6'h34;
   localparam logic [5:0] OFF_EXT_PART_HI  = 6'h35;
   localparam logic [5:0] OFF_EXC_FLAGS_LO = 6'h36;
   localparam logic [5:0] OFF_EXC_FLAGS_HI = 6'h37;
   localparam logic [5:0] OFF_EXC_MASK_LO  = 6'h38;
   localparam logic [5:0] OFF_EXC_MASK_HI  = 6'h39;
   localparam logic [5:0] OFF_GROUPS_REL   = 6'h3a;
   localparam logic [5:0] OFF_CLASS6_SEL   = 6'h3b;
   // own choice: stands beyond the printed map
   localparam logic [5:0] OFF_STROBE_CTRL  = 6'h3c;

   // reset values
   localparam logic [7:0] RST_ZERO         = 8'h00;
   localparam logic [7:0] RST_SEC_REMOVAL  = 8'h09;
   localparam logic [7:0] RST_PROD_AWARE   = 8'h03;
   localparam logic [31:0] RST_MAX_PRELOAD = 32'h003b0000;

   // retention classes
   typedef enum logic [2:0] {
      EMMCXM_CLS_RO   = 3'h0,  // read only
      EMMCXM_CLS_OTP  = 3'h1,  // one-time, readable or not
      EMMCXM_CLS_PERS = 3'h2,  // multi-write, survives cmd0 and hw reset, reloaded on power loss
      EMMCXM_CLS_PWR  = 3'h3,  // writable once, cleared by power/hw reset
      EMMCXM_CLS_VOL  = 3'h4,  // multi-write, cleared by any reset
      EMMCXM_CLS_NONE = 3'h5   // reserved
   } emmcxm_cls_t;

   // timing figures, in their own units
   localparam int unsigned INIT_NORMAL_MS   = 1000;
   localparam int unsigned INIT_PART_MS     = 3000;
   localparam int unsigned SHUTDOWN_SHORT_MS = 100;
   localparam longint unsigned CYC_PER_MS   = CLK_HZ / 1000;
   localparam longint unsigned INIT_NORMAL_CYC = INIT_NORMAL_MS * CYC_PER_MS;
   localparam longint unsigned INIT_PART_CYC   = INIT_PART_MS * CYC_PER_MS;
   localparam longint unsigned SHUTDOWN_CYC    = SHUTDOWN_SHORT_MS * CYC_PER_MS;
   localparam int unsigned CNT_W = 32;

   // strobe control bits
   localparam int unsigned STB_HS400_BIT = 0;
   localparam int unsigned STB_PART_BIT  = 1;
endpackage

// *** emmcxm_mem.sv ***
// emmcxm_mem: byte store for the wide multi-byte fields
// assumes one write port and registered read data; the read register also
// carries bypass data so the owner's read port comes straight from a flop
`timescale 1ns/1ns
module emmcxm_mem #(
   parameter int unsigned DEPTH = 64,
   parameter int unsigned AW    = 6
) (
   input  wire logic          clock,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   input  wire logic          rsel,
   input  wire logic [7:0]    bypass,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clock) begin
      rdata <= rsel ? mem[raddr] : bypass;
   end
endmodule // emmcxm_mem

// *** emmcxm_strobe.sv ***
// emmcxm_strobe: drives the read strobe pin beside outgoing read data
// assumes link clock is already synchronised and edge detected upstream
`timescale 1ns/1ns
module emmcxm_strobe (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic hs400,
   input  wire logic link_edge,
   input  wire logic read_burst,
   input  wire logic crc_status,
   output logic      stb_out,
   output logic      stb_oe
);
   always_ff @(posedge clock) begin
      if (srst) begin
         stb_oe <= 1'b0;
      end else begin
         stb_oe <= hs400 && (read_burst || crc_status);
      end
   end

   // toggle only while read data flows; otherwise park low
   always_ff @(posedge clock) begin
      if (srst) begin
         stb_out <= 1'b0;
      end else if (hs400 && read_burst && link_edge) begin
         stb_out <= ~stb_out;
      end else if (!(hs400 && read_burst)) begin
         stb_out <= 1'b0;
      end
   end

   property p_oe_follows;
      @(posedge clock) disable iff (srst)
      !(hs400 && (read_burst || crc_status)) |=> !stb_oe;
   endproperty
   a_oe_follows: assert property (p_oe_follows)
      else $error("strobe driven outside read or crc status");

   property p_no_toggle;
      @(posedge clock) disable iff (srst)
      !read_burst |=> $stable(stb_out) || !stb_out;
   endproperty
   a_no_toggle: assert property (p_no_toggle)
      else $error("strobe toggled outside a read burst");
endmodule // emmcxm_strobe

// *** emmcxm_host_model.sv ***
// emmcxm_host_model: host side of the link; makes the link clock, captures the strobe
// assumes the bench opens and closes frames with frame_en
`timescale 1ns/1ns
module emmcxm_host_model #(
   parameter int unsigned HALF_NS     = 80,
   parameter int unsigned INIT_ALLOW  = 205,
   parameter int unsigned READ_TO_MS  = 100,
   parameter int unsigned WRITE_TO_MS = 350,
   parameter int unsigned ERASE_TO_MS = 20,
   parameter int unsigned OFF_WAIT    = 55
) (
   input  wire logic frame_en,
   input  wire logic stb_o,
   input  wire logic stb_oe,
   output logic      link_clk,
   output int        cap_cnt
);
   wire  strobe_pin = stb_oe ? stb_o : 1'bz;
   logic prev_pin   = 1'bz;
   int   edges      = 0;

   assign cap_cnt = edges;

   // clock stands low between frames; start offset keeps it out of phase with the core
   initial begin
      link_clk = 1'b0;
      #3;
      forever begin
         #(HALF_NS);
         link_clk = frame_en ? ~link_clk : 1'b0;
      end
   end

   // read data is taken on both strobe edges; leaving high impedance is no edge
   always @(strobe_pin) begin
      if (prev_pin !== 1'bz && strobe_pin !== 1'bz) edges <= edges + 1;
      prev_pin = strobe_pin;
   end
endmodule // emmcxm_host_model

// *** tb.sv ***
// tb: self-checking bench for the mode-segment register bank
// assumes emmcxm_pkg and the host model are compiled before it
`timescale 1ns/1ns
module tb;
   typedef struct packed {
      logic       do_wr;
      logic [5:0] a;
      logic [7:0] d;
      logic [7:0] exp;
   } emmcxm_row_t;

   logic        clock        = 1'b0;
   logic        srst         = 1'b1;
   logic        power_on_rst = 1'b1;
   logic        hw_rst_n     = 1'b1;
   logic        cmd0_rst     = 1'b0;
   logic [5:0]  addr         = 6'h00;
   logic [7:0]  wdata        = 8'h00;
   logic        wr           = 1'b0;
   logic        rd           = 1'b0;
   logic        read_burst   = 1'b0;
   logic        crc_status   = 1'b0;
   logic        frame_en     = 1'b0;
   logic [7:0]  fw_res       = 8'h5c;
   logic [7:0]  batch_fail   = 8'h21;
   logic [7:0]  batch_res    = 8'h42;
   logic [15:0] exc_flags    = 16'hbeef;
   logic [7:0]  groups_rel   = 8'h17;
   logic        link_clk;
   logic [7:0]  rdata;
   logic        init_done;
   logic        init_timeout;
   logic        shutdown_ready;
   logic        stb_o;
   logic        stb_oe;
   logic        cache_flush_pulse;
   logic [7:0]  v;
   logic        s0;
   int          cap_cnt;
   int          bad_count    = 0;
   int          compares     = 0;
   int          n;
   int          k;
   int          cnt;

   // bytes seen after reset, after writes, at the read-only places and at the write-only opcode
   emmcxm_row_t rows [18] = '{
      '{1'b0, 6'h10, 8'h00, 8'h09}, '{1'b0, 6'h11, 8'h00, 8'h03},
      '{1'b0, 6'h3b, 8'h00, 8'h00}, '{1'b1, 6'h3b, 8'h55, 8'h55},
      '{1'b1, 6'h38, 8'ha5, 8'ha5}, '{1'b1, 6'h39, 8'h5a, 8'h5a},
      '{1'b1, 6'h21, 8'h01, 8'h01}, '{1'b1, 6'h25, 8'h3c, 8'h3c},
      '{1'b1, 6'h33, 8'hc3, 8'hc3}, '{1'b1, 6'h1a, 8'hff, 8'h5c},
      '{1'b1, 6'h12, 8'hff, 8'h00}, '{1'b1, 6'h14, 8'hff, 8'h3b},
      '{1'b1, 6'h23, 8'hff, 8'h21}, '{1'b1, 6'h24, 8'hff, 8'h42},
      '{1'b1, 6'h36, 8'h00, 8'hef}, '{1'b1, 6'h37, 8'h00, 8'hbe},
      '{1'b1, 6'h3a, 8'h00, 8'h17}, '{1'b1, 6'h1d, 8'h07, 8'h00}};

   initial begin
      forever #5 clock = ~clock;
   end

   emmcxm_bank #(
      .INIT_NORMAL_CYC (200),
      .INIT_PART_CYC   (300),
      .SHUTDOWN_CYC    (50)
   ) emmcxm_bank_inst (
      .clock              (clock),
      .srst               (srst),
      .power_on_rst       (power_on_rst),
      .hw_rst_n           (hw_rst_n),
      .cmd0_rst           (cmd0_rst),
      .addr               (addr),
      .wdata              (wdata),
      .wr                 (wr),
      .rd                 (rd),
      .rdata              (rdata),
      .link_clk           (link_clk),
      .read_burst         (read_burst),
      .crc_status         (crc_status),
      .fw_result_in       (fw_res),
      .batch_fail_in      (batch_fail),
      .batch_result_in    (batch_res),
      .exc_flags_in       (exc_flags),
      .groups_rel_in      (groups_rel),
      .init_done          (init_done),
      .init_timeout       (init_timeout),
      .shutdown_ready     (shutdown_ready),
      .read_strobe_pin_o  (stb_o),
      .read_strobe_pin_oe (stb_oe),
      .cache_flush_pulse  (cache_flush_pulse)
   );

   emmcxm_host_model emmcxm_host_model_inst (
      .frame_en (frame_en),
      .stb_o    (stb_o),
      .stb_oe   (stb_oe),
      .link_clk (link_clk),
      .cap_cnt  (cap_cnt)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic rd_byte(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // 0 = cmd0, 1 = hardware pin, 2 = power loss; long tail covers init and clearing
   task automatic pulse_reset(input int kind);
      @(posedge clock);
      case (kind)
         0: cmd0_rst <= 1'b1;
         1: hw_rst_n <= 1'b0;
         default: begin
            srst <= 1'b1;
            power_on_rst <= 1'b1;
         end
      endcase
      repeat (6) @(posedge clock);
      cmd0_rst <= 1'b0;
      hw_rst_n <= 1'b1;
      srst <= 1'b0;
      power_on_rst <= 1'b0;
      repeat (210) @(posedge clock);
   endtask

   task automatic report_and_stop;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #300000;
      bad_count++;
      report_and_stop;
   end

   initial begin
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      power_on_rst <= 1'b0;
      for (n = 0; n < 205 && init_done !== 1'b1; n++) @(posedge clock);
      check(init_done, 1'b1);
      check(init_timeout, 1'b0);
      repeat (70) @(posedge clock);
      for (n = 0; n < 18; n++) begin
         if (rows[n].do_wr) wr_byte(rows[n].a, rows[n].d);
         rd_byte(rows[n].a, v);
         check(v, rows[n].exp);
      end
      // status inputs move; read-only bytes follow them and still ignore writes
      fw_res <= 8'ha3;
      exc_flags <= 16'h1234;
      batch_res <= 8'h6e;
      wr_byte(6'h1a, 8'h00);
      rd_byte(6'h1a, v);
      check(v, 8'ha3);
      rd_byte(6'h37, v);
      check(v, 8'h12);
      rd_byte(6'h24, v);
      check(v, 8'h6e);
      for (k = 0; k < 3; k++) begin
         wr_byte(6'h11, 8'h01);
         wr_byte(6'h3b, 8'h55);
         pulse_reset(k);
         rd_byte(6'h11, v);
         check(v, (k == 2) ? 8'h03 : 8'h01);
         rd_byte(6'h3b, v);
         check(v, 8'h00);
      end
      // flush request must give exactly one pulse and read back as zero
      wr_byte(6'h20, 8'h01);
      cnt = 0;
      repeat (4) begin
         #1 cnt += int'(cache_flush_pulse === 1'b1);
         @(posedge clock);
      end
      check(cnt[15:0], 16'h0001);
      rd_byte(6'h20, v);
      check(v, 8'h00);
      wr_byte(6'h22, 8'h01);
      for (n = 0; n < 55 && shutdown_ready !== 1'b1; n++) @(posedge clock);
      check(shutdown_ready, 1'b1);
      // strobe stays released outside hs400 even with a read running
      frame_en <= 1'b1;
      read_burst <= 1'b1;
      repeat (30) @(posedge clock);
      check(stb_oe, 1'b0);
      read_burst <= 1'b0;
      wr_byte(6'h3c, 8'h01);
      read_burst <= 1'b1;
      repeat (60) @(posedge clock);
      check(stb_oe, 1'b1);
      check(cap_cnt != 0, 1'b1);
      read_burst <= 1'b0;
      repeat (5) @(posedge clock);
      check(stb_oe, 1'b0);
      #1 s0 = stb_o;
      cnt = 0;
      repeat (40) begin
         @(posedge clock);
         #1 cnt += int'(stb_o !== s0);
      end
      check(cnt[15:0], 16'h0000);
      crc_status <= 1'b1;
      repeat (30) @(posedge clock);
      check(stb_oe, 1'b1);
      crc_status <= 1'b0;
      frame_en <= 1'b0;
      repeat (5) @(posedge clock);
      check(stb_oe, 1'b0);
      report_and_stop;
   end
endmodule // tb
